/* File: rtl/dpram_pkg.sv */
// Purpose: Shared constants and carriers for the dual-port RAM access control
// Assumes: Single 250 MHz clock, synchronous active-high reset
// Notes: Address map, window and cycle timing constants
package dpram_pkg;

  // ==========================================================================
  // Local address map
  localparam logic [15:0] DPRAM_LOC_RAM_BASE = 16'h8000;
  localparam logic [15:0] DPRAM_LOC_RAM_LAST = 16'hBFFF;
  localparam logic [15:0] DPRAM_SRAM_BASE = 16'h7F00;
  localparam logic [15:0] DPRAM_SRAM_LAST = 16'h7FFF;
  localparam logic [15:0] DPRAM_ROM_BASE = 16'h0000;
  localparam int DPRAM_RAM_BYTES = 16384;
  localparam int DPRAM_RAM_AW = 14;
  localparam int DPRAM_SRAM_BYTES = 256;
  localparam int DPRAM_ROM_MAX = 8192;
  localparam int DPRAM_ROM_AW = 13;
  localparam int DPRAM_ROM_STEP_SMALL = 2048;
  localparam int DPRAM_ROM_STEP_LARGE = 4096;
  localparam int DPRAM_ROM_SMALL_MAX = 4096;

  // ==========================================================================
  // Bus-side window
  localparam int DPRAM_SYS_AW = 20;
  localparam int DPRAM_WIN_SHIFT = 12;
  localparam logic [1:0] DPRAM_RSV_NONE = 2'h0;
  localparam logic [1:0] DPRAM_RSV_8K = 2'h1;
  localparam logic [1:0] DPRAM_RSV_12K = 2'h2;
  localparam logic [DPRAM_RAM_AW-1:0] DPRAM_RSV_8K_BYTES = 14'h2000;
  localparam logic [DPRAM_RAM_AW-1:0] DPRAM_RSV_12K_BYTES = 14'h3000;

  // ==========================================================================
  // Timing
  localparam int DPRAM_CLK_MHZ = 250;
  localparam int DPRAM_RAM_CYC_NS = 40;
  localparam int DPRAM_RAM_CYC = (DPRAM_RAM_CYC_NS * DPRAM_CLK_MHZ + 999) / 1000;
  localparam int DPRAM_REF_NS = 15600;
  localparam int DPRAM_REF_CYC = (DPRAM_REF_NS * DPRAM_CLK_MHZ) / 1000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } dpram_loc_req_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [DPRAM_SYS_AW-1:0] addr;
    logic [7:0] wdata;
  } dpram_sys_req_t;

  typedef struct packed {
    logic [7:0] win_base;
    logic [1:0] rsv_sel;
    logic rom_large;
    logic [1:0] rom_banks;
    logic bus_master;
  } dpram_cfg_t;

  typedef enum logic [1:0] {DPRAM_SRC_LOC, DPRAM_SRC_SYS, DPRAM_SRC_REF} dpram_src_t;

endpackage : dpram_pkg

/* File: rtl/dpram_refresh.sv */
// Purpose: Refresh request timer for the shared dynamic RAM
// Assumes: Single clock, synchronous reset
// Notes: Request holds until acknowledged
module dpram_refresh #(
  parameter int REF_CYC = dpram_pkg::DPRAM_REF_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_ack,
  output logic o_req
);
  import dpram_pkg::*;

  // ==========================================================================
  // Interval counter
  logic [15:0] cnt_q, cnt_d;
  logic req_q, req_d;

  always_comb begin
    cnt_d = cnt_q + 16'h0001;
    req_d = req_q & ~i_ack;
    if (cnt_q == 16'(REF_CYC - 1)) begin
      cnt_d = 16'h0000;
      req_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      cnt_q <= 16'h0000;
      req_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      req_q <= req_d;
    end
  end

  assign o_req = req_q;

endmodule : dpram_refresh

/* File: rtl/dpram_arbiter.sv */
// Purpose: Three-way serializer for RAM cycles
// Assumes: Requests hold until granted
// Notes: Refresh first, then round robin between local and bus
module dpram_arbiter (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_loc_req,
  input wire logic i_sys_req,
  input wire logic i_ref_req,
  input wire logic i_busy,
  output logic o_start,
  output dpram_pkg::dpram_src_t o_src
);
  import dpram_pkg::*;

  // ==========================================================================
  // Grant selection
  logic last_sys_q, last_sys_d;

  always_comb begin
    o_start = 1'b0;
    o_src = DPRAM_SRC_LOC;
    last_sys_d = last_sys_q;
    if (!i_busy) begin
      if (i_ref_req) begin
        o_start = 1'b1;
        o_src = DPRAM_SRC_REF;
      end else if (i_loc_req && (!i_sys_req || last_sys_q)) begin
        o_start = 1'b1;
        o_src = DPRAM_SRC_LOC;
        last_sys_d = 1'b0;
      end else if (i_sys_req) begin
        o_start = 1'b1;
        o_src = DPRAM_SRC_SYS;
        last_sys_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      last_sys_q <= 1'b0;
    end else begin
      last_sys_q <= last_sys_d;
    end
  end

endmodule : dpram_arbiter

/* File: rtl/dpram_access_ctrl.sv */
// Purpose: Dual-port RAM access, address decode and protection
// Assumes: Local and bus requests hold until done pulse
// Notes: ROM and static RAM arrays are internal
//
// Contract
// - Bus masters can never reach the on-board I/O resources.
// - ROM, static RAM, timers and interrupt control answer only the local processor.
// - In slave mode the local processor never gets the system bus; as master it may.
// - Both the local processor and bus masters read and write one shared RAM.
// - The shared RAM holds 16K bytes.
// - Local RAM accesses never use the system bus.
// - The RAM is refreshed automatically whatever the traffic.
// - Locally the shared RAM appears at 8000 to BFFF hex.
// - The bus window base sits on any 4K-byte boundary.
// - The bus window may lie anywhere in a 1 MB address space.
// - 8K or 12K bytes may be reserved locally, invisible to the bus.
// - 256 bytes of static RAM sit at 7F00 to 7FFF, local only.
// - ROM reads finish with no wait states.
// - ROM decode covers up to 8K in 2K steps to 4K or 4K steps to 8K.
// - A bus write to the window base sets a flag, a local read of it clears it.
module dpram_access_ctrl #(
  parameter int REF_CYC = dpram_pkg::DPRAM_REF_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input dpram_pkg::dpram_cfg_t i_cfg,
  input dpram_pkg::dpram_loc_req_t i_loc,
  input wire logic i_loc_io,
  input dpram_pkg::dpram_sys_req_t i_sys,
  input wire logic i_sys_io,
  input wire logic [7:0] i_rom_wdata,
  input wire logic i_rom_we,
  input wire logic [12:0] i_rom_waddr,
  output logic o_loc_done,
  output logic [7:0] o_loc_rdata,
  output logic o_loc_ext,
  output logic o_loc_io_sel,
  output logic o_sys_done,
  output logic [7:0] o_sys_rdata,
  output logic o_flag_irq,
  output logic o_ref_busy
);
  import dpram_pkg::*;

  // ==========================================================================
  // Decode functions
  function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic rom_hit(input logic [15:0] a, input dpram_cfg_t c);
    logic [15:0] lim;
    lim = c.rom_large ? 16'(({14'h0, c.rom_banks} + 16'h1) * 16'(DPRAM_ROM_STEP_LARGE))
                      : 16'(({15'h0, c.rom_banks[0]} + 16'h1) * 16'(DPRAM_ROM_STEP_SMALL));
    rom_hit = (a >= DPRAM_ROM_BASE) && (a < lim) && (a < 16'(DPRAM_ROM_MAX));
  endfunction : rom_hit

  function automatic logic sys_win_hit(input logic [DPRAM_SYS_AW-1:0] a,
                                       input dpram_cfg_t c);
    logic [DPRAM_SYS_AW-1:0] off;
    logic [DPRAM_RAM_AW-1:0] lo;
    off = a - {c.win_base, 12'h000};
    lo = (c.rsv_sel == DPRAM_RSV_8K) ? DPRAM_RSV_8K_BYTES :
         (c.rsv_sel == DPRAM_RSV_12K) ? DPRAM_RSV_12K_BYTES : 14'h0000;
    sys_win_hit = (a >= {c.win_base, 12'h000}) &&
                  (off < 20'(DPRAM_RAM_BYTES) - 20'(lo));
  endfunction : sys_win_hit

  // ==========================================================================
  // Storage
  logic [7:0] dram_mem [DPRAM_RAM_BYTES];
  logic [7:0] sram_mem [DPRAM_SRAM_BYTES];
  logic [7:0] rom_mem [DPRAM_ROM_MAX];

  // ==========================================================================
  // Local and bus decode
  logic loc_mem, loc_ram, loc_sram, loc_rom, loc_ext, sys_hit;
  logic [DPRAM_RAM_AW-1:0] sys_off, sys_lo;

  always_comb begin
    loc_mem = i_loc.req && !i_loc_io;
    loc_ram = loc_mem && in_range(i_loc.addr, DPRAM_LOC_RAM_BASE, DPRAM_LOC_RAM_LAST);
    loc_sram = loc_mem && in_range(i_loc.addr, DPRAM_SRAM_BASE, DPRAM_SRAM_LAST);
    loc_rom = loc_mem && !i_loc.wr && rom_hit(i_loc.addr, i_cfg);
    loc_ext = i_loc.req && !loc_ram && !loc_sram && !loc_rom && !i_loc_io &&
              i_cfg.bus_master;
    sys_hit = i_sys.req && !i_sys_io && sys_win_hit(i_sys.addr, i_cfg);
    sys_lo = (i_cfg.rsv_sel == DPRAM_RSV_8K) ? DPRAM_RSV_8K_BYTES :
             (i_cfg.rsv_sel == DPRAM_RSV_12K) ? DPRAM_RSV_12K_BYTES : 14'h0000;
    sys_off = DPRAM_RAM_AW'(i_sys.addr - {i_cfg.win_base, 12'h000}) + sys_lo;
  end

  // ==========================================================================
  // Arbitration and refresh
  logic ref_req, arb_start, cyc_busy;
  dpram_src_t arb_src;
  logic loc_pend_q, loc_pend_d, sys_pend_q, sys_pend_d;

  dpram_refresh #(.REF_CYC(REF_CYC)) u_refresh (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_ack(arb_start && arb_src == DPRAM_SRC_REF),
    .o_req(ref_req)
  );

  dpram_arbiter u_arbiter (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_loc_req(loc_ram && !loc_pend_q),
    .i_sys_req(sys_hit && !sys_pend_q),
    .i_ref_req(ref_req),
    .i_busy(cyc_busy),
    .o_start(arb_start),
    .o_src(arb_src)
  );

  // ==========================================================================
  // RAM cycle sequencer
  typedef enum logic [1:0] {DPRAM_ST_IDLE, DPRAM_ST_CYC, DPRAM_ST_DONE} dpram_st_t;
  dpram_st_t st_q, st_d;
  dpram_src_t src_q, src_d;
  logic [3:0] cyc_q, cyc_d;
  logic [DPRAM_RAM_AW-1:0] ram_a_q, ram_a_d;
  logic ram_wr_q, ram_wr_d;
  logic [7:0] ram_wd_q, ram_wd_d;

  assign cyc_busy = (st_q != DPRAM_ST_IDLE);

  always_comb begin
    st_d = st_q;
    src_d = src_q;
    cyc_d = cyc_q;
    ram_a_d = ram_a_q;
    ram_wr_d = ram_wr_q;
    ram_wd_d = ram_wd_q;
    loc_pend_d = loc_pend_q && loc_ram;
    sys_pend_d = sys_pend_q && sys_hit;
    unique case (st_q)
      DPRAM_ST_IDLE: begin
        if (arb_start) begin
          st_d = DPRAM_ST_CYC;
          src_d = arb_src;
          cyc_d = 4'(DPRAM_RAM_CYC - 1);
          ram_wr_d = 1'b0;
          ram_wd_d = 8'h00;
          ram_a_d = 14'h0000;
          if (arb_src == DPRAM_SRC_LOC) begin
            ram_a_d = i_loc.addr[DPRAM_RAM_AW-1:0];
            ram_wr_d = i_loc.wr;
            ram_wd_d = i_loc.wdata;
          end else if (arb_src == DPRAM_SRC_SYS) begin
            ram_a_d = sys_off;
            ram_wr_d = i_sys.wr;
            ram_wd_d = i_sys.wdata;
          end
        end
      end
      DPRAM_ST_CYC: begin
        cyc_d = cyc_q - 4'h1;
        if (cyc_q == 4'h0) begin
          st_d = DPRAM_ST_DONE;
        end
      end
      DPRAM_ST_DONE: begin
        st_d = DPRAM_ST_IDLE;
        if (src_q == DPRAM_SRC_LOC) begin
          loc_pend_d = 1'b1;
        end
        if (src_q == DPRAM_SRC_SYS) begin
          sys_pend_d = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_q <= DPRAM_ST_IDLE;
      src_q <= DPRAM_SRC_LOC;
      cyc_q <= 4'h0;
      ram_a_q <= 14'h0000;
      ram_wr_q <= 1'b0;
      ram_wd_q <= 8'h00;
      loc_pend_q <= 1'b0;
      sys_pend_q <= 1'b0;
    end else begin
      st_q <= st_d;
      src_q <= src_d;
      cyc_q <= cyc_d;
      ram_a_q <= ram_a_d;
      ram_wr_q <= ram_wr_d;
      ram_wd_q <= ram_wd_d;
      loc_pend_q <= loc_pend_d;
      sys_pend_q <= sys_pend_d;
    end
  end

  // ==========================================================================
  // Memory arrays
  always_ff @(posedge i_sys_clk) begin
    if (st_q == DPRAM_ST_DONE && ram_wr_q && src_q != DPRAM_SRC_REF) begin
      dram_mem[ram_a_q] <= ram_wd_q;
    end
    if (loc_sram && i_loc.wr) begin
      sram_mem[i_loc.addr[7:0]] <= i_loc.wdata;
    end
    if (i_rom_we) begin
      rom_mem[i_rom_waddr] <= i_rom_wdata;
    end
  end

  // ==========================================================================
  // Answers and flag
  logic loc_done_d, sys_done_d, flag_d, loc_ext_d, io_sel_d, ref_busy_d;
  logic [7:0] loc_rd_d, sys_rd_d;
  logic loc_done_q, sys_done_q, flag_q, loc_ext_q, io_sel_q, ref_busy_q;
  logic [7:0] loc_rd_q, sys_rd_q;
  logic base_wr, base_rd;

  always_comb begin
    loc_done_d = 1'b0;
    sys_done_d = 1'b0;
    loc_rd_d = loc_rd_q;
    sys_rd_d = sys_rd_q;
    base_wr = st_q == DPRAM_ST_DONE && src_q == DPRAM_SRC_SYS && ram_wr_q &&
              ram_a_q == sys_lo;
    base_rd = st_q == DPRAM_ST_DONE && src_q == DPRAM_SRC_LOC && !ram_wr_q &&
              ram_a_q == sys_lo;
    flag_d = base_wr | (flag_q & ~base_rd);
    if (st_q == DPRAM_ST_DONE && src_q == DPRAM_SRC_LOC) begin
      loc_done_d = 1'b1;
      loc_rd_d = dram_mem[ram_a_q];
    end else if (loc_rom && !loc_done_q) begin
      loc_done_d = 1'b1;
      loc_rd_d = rom_mem[DPRAM_ROM_AW'(i_loc.addr)];
    end else if (loc_sram && !loc_done_q) begin
      loc_done_d = 1'b1;
      loc_rd_d = sram_mem[i_loc.addr[7:0]];
    end
    if (st_q == DPRAM_ST_DONE && src_q == DPRAM_SRC_SYS) begin
      sys_done_d = 1'b1;
      sys_rd_d = ram_wr_q ? 8'h00 : dram_mem[ram_a_q];
    end
    loc_ext_d = loc_ext;
    io_sel_d = i_loc.req && i_loc_io;
    ref_busy_d = st_q != DPRAM_ST_IDLE && src_q == DPRAM_SRC_REF;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      loc_done_q <= 1'b0;
      sys_done_q <= 1'b0;
      loc_rd_q <= 8'h00;
      sys_rd_q <= 8'h00;
      flag_q <= 1'b0;
      loc_ext_q <= 1'b0;
      io_sel_q <= 1'b0;
      ref_busy_q <= 1'b0;
    end else begin
      loc_done_q <= loc_done_d;
      sys_done_q <= sys_done_d;
      loc_rd_q <= loc_rd_d;
      sys_rd_q <= sys_rd_d;
      flag_q <= flag_d;
      loc_ext_q <= loc_ext_d;
      io_sel_q <= io_sel_d;
      ref_busy_q <= ref_busy_d;
    end
  end

  assign o_loc_done = loc_done_q;
  assign o_loc_rdata = loc_rd_q;
  assign o_loc_ext = loc_ext_q;
  assign o_loc_io_sel = io_sel_q;
  assign o_sys_done = sys_done_q;
  assign o_sys_rdata = sys_rd_q;
  assign o_flag_irq = flag_q;
  assign o_ref_busy = ref_busy_q;

  // ==========================================================================
  // Checks
  a_slave_no_bus: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !i_cfg.bus_master |=> !o_loc_ext) else $error("local bus access in slave mode");
  a_io_bus_block: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (i_sys.req && i_sys_io && !cyc_busy) |=> !(st_q == DPRAM_ST_CYC && src_q == DPRAM_SRC_SYS))
    else $error("bus reached local io");
  a_rom_no_wait: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (loc_rom && !loc_done_q && !cyc_busy) |=> o_loc_done) else $error("rom wait state");
  a_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    base_wr |=> o_flag_irq) else $error("flag not set");
  a_flag_clear: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (base_rd && !base_wr) |=> !o_flag_irq) else $error("flag not cleared");
  a_ref_served: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    $rose(ref_req) |-> ##[1:20] (st_q == DPRAM_ST_CYC && src_q == DPRAM_SRC_REF))
    else $error("refresh starved");
  a_cycle_len: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (st_q == DPRAM_ST_IDLE && arb_start) |=>
    (st_q == DPRAM_ST_CYC && cyc_q == 4'(DPRAM_RAM_CYC - 1)) ##9
    (st_q == DPRAM_ST_CYC && cyc_q == 4'h0) ##1 (st_q == DPRAM_ST_DONE))
    else $error("ram cycle length");
  a_rsv_hidden: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    sys_hit |-> (sys_off >= sys_lo)) else $error("reserved ram visible");

endmodule : dpram_access_ctrl

/* File: verification/dpram_far_model.sv */
// Purpose: Far-side requesters, on-board processor and bus master
// Assumes: Requests change on the falling clock edge
// Notes: Released address, data and write lines show inverted values; req and io lines drop to 0
module dpram_far_model (
  input wire logic i_sys_clk,
  input wire logic i_loc_done,
  input wire logic [7:0] i_loc_rdata,
  input wire logic i_sys_done,
  input wire logic [7:0] i_sys_rdata,
  output dpram_pkg::dpram_loc_req_t o_loc,
  output logic o_loc_io,
  output dpram_pkg::dpram_sys_req_t o_sys,
  output logic o_sys_io
);
  timeunit 1ns;
  timeprecision 1ps;
  import dpram_pkg::*;

  initial begin
    o_loc = '0;
    o_sys = '0;
    o_loc_io = 1'b0;
    o_sys_io = 1'b0;
  end

  // ==========================================================================
  // Processor side
  task automatic loc_op(input logic wr, input logic io, input logic [15:0] a,
                        input logic [7:0] wd, input int lim, output logic [7:0] rd,
                        output logic ok, output int n);
    n = 0;
    ok = 1'b0;
    rd = 8'h00;
    @(negedge i_sys_clk);
    o_loc_io = io;
    o_loc = '{req: 1'b1, wr: wr, addr: a, wdata: wd};
    while (!ok && n < lim) begin
      @(negedge i_sys_clk);
      n++;
      if (i_loc_done === 1'b1) begin
        ok = 1'b1;
        rd = i_loc_rdata;
      end
    end
    o_loc = '{req: 1'b0, wr: ~wr, addr: ~a, wdata: ~wd};
    o_loc_io = 1'b0;
  endtask : loc_op

  // ==========================================================================
  // Bus master side
  task automatic sys_op(input logic wr, input logic io, input logic [19:0] a,
                        input logic [7:0] wd, input int lim, output logic [7:0] rd,
                        output logic ok, output int n);
    n = 0;
    ok = 1'b0;
    rd = 8'h00;
    @(negedge i_sys_clk);
    o_sys_io = io;
    o_sys = '{req: 1'b1, wr: wr, addr: a, wdata: wd};
    while (!ok && n < lim) begin
      @(negedge i_sys_clk);
      n++;
      if (i_sys_done === 1'b1) begin
        ok = 1'b1;
        rd = i_sys_rdata;
      end
    end
    o_sys = '{req: 1'b0, wr: ~wr, addr: ~a, wdata: ~wd};
    o_sys_io = 1'b0;
  endtask : sys_op

endmodule : dpram_far_model

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench for the dual-port RAM access control
// Assumes: Refresh interval shortened to 50 cycles
// Notes: Random data and window base from a fixed seed
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dpram_pkg::*;

  logic i_sys_clk = 1'b0;
  logic i_srst = 1'b1;
  dpram_cfg_t cfg = '0;
  dpram_loc_req_t loc;
  dpram_sys_req_t sys;
  logic loc_io, sys_io, loc_done, sys_done, loc_ext, io_sel, flag, ref_busy;
  logic rom_we = 1'b0;
  logic [12:0] rom_a = '0;
  logic [7:0] rom_d = '0;
  logic [7:0] loc_rd, sys_rd, rd, rd2, d, d2;
  logic ok, ok2;
  logic ext_seen = 1'b0;
  logic io_seen = 1'b0;
  logic ref_seen = 1'b0;
  int num_errors = 0;
  int total_checks = 0;
  int lat, lat2, sz;
  logic [7:0] rom_exp [8];
  logic [19:0] base;
  logic [13:0] o, o2;
  logic [3:0] okb [3] = '{4'h1, 4'h3, 4'h3};

  always #2 i_sys_clk = ~i_sys_clk;

  dpram_access_ctrl #(.REF_CYC(50)) u_dpram_access_ctrl (
    .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cfg(cfg), .i_loc(loc), .i_loc_io(loc_io),
    .i_sys(sys), .i_sys_io(sys_io), .i_rom_wdata(rom_d), .i_rom_we(rom_we),
    .i_rom_waddr(rom_a), .o_loc_done(loc_done), .o_loc_rdata(loc_rd), .o_loc_ext(loc_ext),
    .o_loc_io_sel(io_sel), .o_sys_done(sys_done), .o_sys_rdata(sys_rd),
    .o_flag_irq(flag), .o_ref_busy(ref_busy));

  dpram_far_model u_dpram_far_model (
    .i_sys_clk(i_sys_clk), .i_loc_done(loc_done), .i_loc_rdata(loc_rd),
    .i_sys_done(sys_done), .i_sys_rdata(sys_rd), .o_loc(loc), .o_loc_io(loc_io),
    .o_sys(sys), .o_sys_io(sys_io));

  always @(negedge i_sys_clk) begin
    if (loc_ext === 1'b1) ext_seen = 1'b1;
    if (io_sel === 1'b1) io_seen = 1'b1;
    if (ref_busy === 1'b1) ref_seen = 1'b1;
  end

  // ==========================================================================
  // Checking and reporting
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte

  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  function automatic logic [19:0] win_addr(input logic [13:0] ram_off, input int rsv);
    win_addr = 20'(base + 20'(ram_off) - 20'(rsv));
  endfunction : win_addr

  task automatic end_test(input string name);
    $display("test %s finished, checks %0d, mismatches %0d", name, total_checks, num_errors);
  endtask : end_test

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic lop(input logic wr, input logic io, input logic [15:0] a,
                     input logic [7:0] wd, input int lim);
    u_dpram_far_model.loc_op(wr, io, a, wd, lim, rd, ok, lat);
  endtask : lop

  task automatic sop(input logic wr, input logic io, input logic [19:0] a,
                     input logic [7:0] wd, input int lim);
    u_dpram_far_model.sys_op(wr, io, a, wd, lim, rd, ok, lat);
  endtask : sop

  initial begin
    repeat (60000) @(posedge i_sys_clk);
    num_errors++;
    print_verdict();
  end

  // ==========================================================================
  // Tests
  initial begin
    void'($urandom(88193));
    repeat (6) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_srst = 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(negedge i_sys_clk);
      rom_exp[k] = 8'($urandom);
      rom_we = 1'b1;
      rom_a = 13'(k * 1024 + k);
      rom_d = rom_exp[k];
    end
    @(negedge i_sys_clk);
    rom_we = 1'b0;
    cfg.rom_large = 1'b1;
    cfg.rom_banks = 2'h1;
    for (int k = 0; k < 8; k++) begin
      lop(1'b0, 1'b0, 16'(k * 1024 + k), 8'h00, 20);
      chk_byte("rom_data", rom_exp[k], rd);
      chk_bit("rom_no_wait", 1'b1, lat == 1);
    end
    for (int j = 0; j < 3; j++) begin
      cfg.rom_large = (j == 2);
      cfg.rom_banks = (j == 1) ? 2'h1 : 2'h0;
      lop(1'b0, 1'b0, 16'(okb[j] * 1024 + okb[j]), 8'h00, 20);
      chk_byte("rom_edge", rom_exp[okb[j]], rd);
      lop(1'b0, 1'b0, 16'((okb[j] + 1) * 1024 + okb[j] + 1), 8'h00, 20);
      chk_bit("rom_beyond", 1'b0, ok);
    end
    end_test("rom");

    for (int k = 0; k < 2; k++) begin
      d = 8'($urandom);
      lop(1'b1, 1'b0, k ? 16'h7FFF : 16'h7F00, d, 200);
      lop(1'b0, 1'b0, k ? 16'h7FFF : 16'h7F00, 8'h00, 200);
      chk_byte("sram_data", d, rd);
    end
    end_test("sram");

    cfg.win_base = 8'($urandom_range(0, 251));
    base = {cfg.win_base, 12'h000};
    for (int i = 0; i < 6; i++) begin
      o = (i == 0) ? 14'h3FFF : (i == 1) ? 14'h0001 : 14'($urandom_range(1, 16383));
      d = 8'($urandom);
      if (i % 2 == 0) begin
        lop(1'b1, 1'b0, 16'(16'h8000 + o), d, 200);
        sop(1'b0, 1'b0, 20'(base + o), 8'h00, 200);
        chk_byte("bus_read", d, rd);
      end else begin
        sop(1'b1, 1'b0, 20'(base + o), d, 200);
        lop(1'b0, 1'b0, 16'(16'h8000 + o), 8'h00, 200);
        chk_byte("local_read", d, rd);
      end
    end
    end_test("shared_ram");

    for (int i = 0; i < 4; i++) begin
      o = 14'($urandom_range(1, 8191));
      o2 = 14'($urandom_range(8192, 16383));
      d = 8'($urandom);
      d2 = 8'($urandom);
      fork
        u_dpram_far_model.loc_op(1'b1, 1'b0, 16'(16'h8000 + o), d, 200, rd, ok, lat);
        u_dpram_far_model.sys_op(1'b1, 1'b0, 20'(base + o2), d2, 200, rd2, ok2, lat2);
      join
      chk_bit("both_served", 1'b1, ok & ok2);
      sop(1'b0, 1'b0, 20'(base + o), 8'h00, 200);
      chk_byte("bus_after", d, rd);
      lop(1'b0, 1'b0, 16'(16'h8000 + o2), 8'h00, 200);
      chk_byte("local_after", d2, rd);
    end
    chk_bit("refresh_seen", 1'b1, ref_seen);
    end_test("concurrent");

    for (int j = 0; j < 2; j++) begin
      cfg.rsv_sel = j ? DPRAM_RSV_12K : DPRAM_RSV_8K;
      sz = j ? 12288 : 8192;
      d = 8'($urandom);
      lop(1'b1, 1'b0, 16'(32768 + 16383), d, 200);
      sop(1'b0, 1'b0, win_addr(14'h3FFF, sz), 8'h00, 200);
      chk_byte("window_top", d, rd);
      sop(1'b0, 1'b0, win_addr(14'h3FFF, sz) + 20'h00001, 8'h00, 40);
      chk_bit("beyond_window", 1'b0, ok);
    end
    cfg.rsv_sel = DPRAM_RSV_NONE;
    end_test("reserve");

    chk_bit("flag_idle", 1'b0, flag);
    sop(1'b1, 1'b0, base, 8'h5A, 200);
    chk_bit("flag_set", 1'b1, flag);
    lop(1'b0, 1'b0, 16'h8001, 8'h00, 200);
    repeat (2) @(negedge i_sys_clk);
    chk_bit("flag_kept", 1'b1, flag);
    lop(1'b0, 1'b0, 16'h8000, 8'h00, 200);
    repeat (2) @(negedge i_sys_clk);
    chk_bit("flag_clear", 1'b0, flag);
    end_test("flag");

    sop(1'b0, 1'b1, base, 8'h00, 40);
    chk_bit("bus_io", 1'b0, ok);
    sop(1'b0, 1'b0, 20'(base - 1), 8'h00, 40);
    chk_bit("bus_outside", 1'b0, ok);
    lop(1'b0, 1'b1, 16'h0010, 8'h00, 20);
    chk_bit("local_io_done", 1'b0, ok);
    chk_bit("local_io_sel", 1'b1, io_seen);
    cfg.bus_master = 1'b0;
    lop(1'b0, 1'b0, 16'hC000, 8'h00, 40);
    chk_bit("slave_no_bus", 1'b0, ok | ext_seen);
    cfg.bus_master = 1'b1;
    lop(1'b0, 1'b0, 16'hC000, 8'h00, 20);
    chk_bit("master_bus", 1'b1, ext_seen);
    end_test("protection");
    print_verdict();
  end

endmodule : tb_top
